// ===== rtl/vrtc_gain.sv
`timescale 1ns/1ps
// Gain decode: one-hot amplifier selects from a 2-bit code
module vrtc_gain
    import vrtc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       clk_en_i,
    // Code in, selects out
    input  wire logic [1:0] code_i,
    output logic            on_o,
    output logic [2:0]      sel_o    // Bit 0 1x, bit 1 2x, bit 2 4x
);

    // Registered decode
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            on_o  <= 1'b0;
            sel_o <= 3'h0;
        end else if (clk_en_i) begin
            on_o <= (code_i != VRTC_GAIN_OFF);
            case (code_i)
                VRTC_GAIN_X1: sel_o <= 3'h1;
                VRTC_GAIN_X2: sel_o <= 3'h2;
                VRTC_GAIN_X4: sel_o <= 3'h4;
                default:      sel_o <= 3'h0;
            endcase
        end
    end

endmodule // vrtc_gain

// ===== rtl/vrtc_pkg.sv
package vrtc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] VRTC_OFS_CONTROL = 4'h0;   // Control register
    localparam logic [3:0] VRTC_OFS_STATUS  = 4'h4;   // Buffer status

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int VRTC_BIT_REF_EN  = 7;   // Reference enable
    localparam int VRTC_BIT_READY   = 6;   // Ready flag
    localparam int VRTC_BIT_TS_EN   = 5;   // Temperature sense enable
    localparam int VRTC_BIT_TS_RNG  = 4;   // Temperature range
    localparam int VRTC_LSB_CMP     = 2;   // Comparator/DAC gain LSB
    localparam int VRTC_LSB_CONV    = 0;   // Converter gain LSB

    // Reset value of the writable control bits
    localparam logic [7:0] VRTC_CTRL_RESET = 8'h00;

    // ************************************************************
    // Gain codes
    // ************************************************************
    localparam logic [1:0] VRTC_GAIN_OFF = 2'h0;   // Output off
    localparam logic [1:0] VRTC_GAIN_X1  = 2'h1;   // Gain 1x
    localparam logic [1:0] VRTC_GAIN_X2  = 2'h2;   // Gain 2x
    localparam logic [1:0] VRTC_GAIN_X4  = 2'h3;   // Gain 4x

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int VRTC_CLK_MHZ      = 20;   // Clock rate in MHz
    localparam int VRTC_BUF_SETTLE_US = 30;  // Buffer settle, microseconds
    localparam int VRTC_BUF_SETTLE_CYC = VRTC_BUF_SETTLE_US * VRTC_CLK_MHZ;
    localparam int VRTC_REF_SETTLE_CYC = 64; // Core settle, cycles

    // AXI responses
    localparam logic [1:0] VRTC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] VRTC_RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/vrtc_settle.sv
`timescale 1ns/1ps
// Settle counter: ready rises COUNT+1 cycles after enable rises
module vrtc_settle
    import vrtc_pkg::*;
#(
    parameter int COUNT = 64
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic clk_en_i,
    // Control
    input  wire logic enable_i,
    output logic      ready_o
);

    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);

    logic [W-1:0] count;   // Cycles since enable

    // Count while enabled, clear when enable falls
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= '0;
        end else if (clk_en_i) begin
            if (!enable_i) begin
                count <= '0;
            end else if (count != LAST) begin
                count <= count + W'(1);
            end
        end
    end

    // Ready once the count is complete
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ready_o <= 1'b0;
        end else if (clk_en_i) begin
            ready_o <= enable_i && (count == LAST);
        end
    end

endmodule // vrtc_settle

// ===== rtl/vrtc_top.sv
`timescale 1ns/1ps
module vrtc_top
    import vrtc_pkg::*;
#(
    parameter bit LOW_VOLT_VARIANT = 1'b1,
    parameter int REF_SETTLE_CYC   = VRTC_REF_SETTLE_CYC,
    parameter int BUF_SETTLE_CYC   = VRTC_BUF_SETTLE_CYC
) (
    // Clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [3:0]  s_axi_awaddr_i,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    // AXI4-Lite write response
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    output logic [1:0]       s_axi_bresp_o,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    input  wire logic [3:0]  s_axi_araddr_i,
    // AXI4-Lite read data
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    // Analogue controls
    output logic             ref_power_o,
    output logic             conv_buf_on_o,
    output logic [2:0]       conv_gain_o,
    output logic             cmp_buf_on_o,
    output logic [2:0]       cmp_gain_o,
    output logic             temp_power_o,
    output logic             temp_high_range_o,
    // Routing to the converter and comparators
    output logic             conv_ch_ref_o,
    output logic             conv_pref_ref_o,
    output logic             cmp_pos_ref_o,
    output logic             dac_src_ref_o,
    output logic             conv_ch_temp_o,
    // Routing requests
    input  wire logic        conv_sel_ref_i,
    input  wire logic        conv_sel_pref_i,
    input  wire logic        cmp_sel_ref_i,
    input  wire logic        dac_sel_ref_i,
    input  wire logic        conv_sel_temp_i
);

    // ************************************************************
    // Control register
    // ************************************************************
    logic       reference_enable;       // Reference on
    logic       temp_sense_enable;      // Sensor powered
    logic       temp_range_select;      // High range when set
    logic [1:0] cmp_dac_gain_select;    // Comparator/DAC gain
    logic [1:0] converter_gain_select;  // Converter gain
    logic       settle_ready;           // Core settled
    logic       reference_ready_flag;   // Read-back ready
    logic       conv_on;                // Converter buffer on
    logic       cmp_on;                 // Comparator buffer on
    logic       conv_buf_ready;         // Converter buffer settled
    logic       cmp_buf_ready;          // Comparator buffer settled

    // ************************************************************
    // AXI4-Lite slave state
    // ************************************************************
    logic        aw_held;     // Write address captured
    logic [3:0]  aw_addr;     // Captured write address
    logic        w_held;      // Write data captured
    logic [31:0] w_data;      // Captured write data
    logic [3:0]  w_strb;      // Captured strobes
    logic        wr_go;       // Both halves present
    logic        rd_go;       // Read accepted
    logic [31:0] next_rdata;  // Read mux

    assign wr_go = aw_held && w_held && !s_axi_bvalid_o;
    assign rd_go = s_axi_arvalid_i && s_axi_arready_o;

    // Write address channel, one write in flight
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held         <= 1'b0;
            aw_addr         <= 4'h0;
            s_axi_awready_o <= 1'b0;
        end else if (clk_en_i) begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                // Address taken
                aw_held         <= 1'b1;
                aw_addr         <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end else begin
                s_axi_awready_o <= !aw_held && !s_axi_bvalid_o;
            end
        end
    end

    // Write data channel
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            w_held         <= 1'b0;
            w_data         <= 32'h0;
            w_strb         <= 4'h0;
            s_axi_wready_o <= 1'b0;
        end else if (clk_en_i) begin
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                // Data taken
                w_held         <= 1'b1;
                w_data         <= s_axi_wdata_i;
                w_strb         <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end else begin
                s_axi_wready_o <= !w_held && !s_axi_bvalid_o;
            end
        end
    end

    // Write response
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= VRTC_RESP_OKAY;
        end else if (clk_en_i) begin
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= (aw_addr == VRTC_OFS_CONTROL ||
                                   aw_addr == VRTC_OFS_STATUS)
                                  ? VRTC_RESP_OKAY : VRTC_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Control register write; ready bit is not stored
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reference_enable      <= VRTC_CTRL_RESET[VRTC_BIT_REF_EN];
            temp_sense_enable     <= VRTC_CTRL_RESET[VRTC_BIT_TS_EN];
            temp_range_select     <= VRTC_CTRL_RESET[VRTC_BIT_TS_RNG];
            cmp_dac_gain_select   <= VRTC_CTRL_RESET[3:2];
            converter_gain_select <= VRTC_CTRL_RESET[1:0];
        end else if (clk_en_i) begin
            if (wr_go && aw_addr == VRTC_OFS_CONTROL && w_strb[0]) begin
                reference_enable      <= w_data[VRTC_BIT_REF_EN];
                temp_sense_enable     <= w_data[VRTC_BIT_TS_EN];
                temp_range_select     <= w_data[VRTC_BIT_TS_RNG];
                cmp_dac_gain_select   <= w_data[VRTC_LSB_CMP +: 2];
                converter_gain_select <= w_data[VRTC_LSB_CONV +: 2];
            end
        end
    end

    // ************************************************************
    // Settling and amplifier decode
    // ************************************************************
    // Core reference settle counter
    vrtc_settle #(.COUNT(REF_SETTLE_CYC)) u_ref_settle (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .enable_i  (reference_enable),
        .ready_o   (settle_ready)
    );

    // Ready flag: forced high on the variant without low voltage
    // Gated by enable so the flag drops in the same cycle as the bit
    assign reference_ready_flag =
        LOW_VOLT_VARIANT ? (settle_ready && reference_enable)
                         : 1'b1;

    // Converter path amplifier
    vrtc_gain u_conv_gain (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .code_i    (reference_enable ? converter_gain_select
                                     : VRTC_GAIN_OFF),
        .on_o      (conv_on),
        .sel_o     (conv_gain_o)
    );

    // Comparator and DAC path amplifier
    vrtc_gain u_cmp_gain (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .code_i    (reference_enable ? cmp_dac_gain_select
                                     : VRTC_GAIN_OFF),
        .on_o      (cmp_on),
        .sel_o     (cmp_gain_o)
    );

    // Buffer settle trackers, status only; software still waits
    vrtc_settle #(.COUNT(BUF_SETTLE_CYC)) u_conv_buf (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .enable_i  (conv_on),
        .ready_o   (conv_buf_ready)
    );

    vrtc_settle #(.COUNT(BUF_SETTLE_CYC)) u_cmp_buf (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clk_en_i  (clk_en_i),
        .enable_i  (cmp_on),
        .ready_o   (cmp_buf_ready)
    );

    assign conv_buf_on_o = conv_on;
    assign cmp_buf_on_o  = cmp_on;

    // ************************************************************
    // Analogue power and routing
    // ************************************************************
    // Registered power and routing controls
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ref_power_o       <= 1'b0;
            temp_power_o      <= 1'b0;
            temp_high_range_o <= 1'b0;
            conv_ch_ref_o     <= 1'b0;
            conv_pref_ref_o   <= 1'b0;
            cmp_pos_ref_o     <= 1'b0;
            dac_src_ref_o     <= 1'b0;
            conv_ch_temp_o    <= 1'b0;
        end else if (clk_en_i) begin
            ref_power_o       <= reference_enable;
            temp_power_o      <= temp_sense_enable;
            temp_high_range_o <= temp_sense_enable &&
                                 temp_range_select;
            conv_ch_ref_o     <= conv_sel_ref_i;
            conv_pref_ref_o   <= conv_sel_pref_i;
            cmp_pos_ref_o     <= cmp_sel_ref_i;
            dac_src_ref_o     <= dac_sel_ref_i;
            conv_ch_temp_o    <= conv_sel_temp_i &&
                                 temp_sense_enable;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Read mux
    always_comb begin
        next_rdata = 32'h0;
        case (s_axi_araddr_i)
            VRTC_OFS_CONTROL: begin
                next_rdata[7:0] = {reference_enable,
                                   reference_ready_flag,
                                   temp_sense_enable,
                                   temp_range_select,
                                   cmp_dac_gain_select,
                                   converter_gain_select};
            end
            VRTC_OFS_STATUS: begin
                next_rdata[1:0] = {cmp_buf_ready, conv_buf_ready};
            end
            default: begin
                next_rdata = 32'h0;
            end
        endcase
    end

    // Read channel, one read in flight
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0;
            s_axi_rresp_o   <= VRTC_RESP_OKAY;
        end else if (clk_en_i) begin
            if (rd_go) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o  <= 1'b1;
                s_axi_rdata_o   <= next_rdata;
                s_axi_rresp_o   <= (s_axi_araddr_i == VRTC_OFS_CONTROL ||
                                    s_axi_araddr_i == VRTC_OFS_STATUS)
                                   ? VRTC_RESP_OKAY : VRTC_RESP_SLVERR;
            end else if (s_axi_rvalid_o) begin
                if (s_axi_rready_i) begin
                    s_axi_rvalid_o <= 1'b0;
                end
            end else begin
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_ready_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        LOW_VOLT_VARIANT && !reference_enable |-> !reference_ready_flag)
        else $error("ready flag high while reference disabled");

    a_ready_early: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        LOW_VOLT_VARIANT && clk_en_i && $rose(reference_enable)
        |=> !reference_ready_flag)
        else $error("ready flag set without settling");

    a_ready_forced: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        !LOW_VOLT_VARIANT |-> reference_ready_flag)
        else $error("ready flag not forced high");

    a_power_follow: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i)
        clk_en_i |=> ref_power_o == $past(reference_enable))
        else $error("reference power does not follow enable");

    a_temp_power: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i |=> temp_power_o == $past(temp_sense_enable))
        else $error("sensor power does not follow enable");

    a_conv_gain: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i && reference_enable &&
        converter_gain_select == VRTC_GAIN_X4 |=> conv_gain_o == 3'h4)
        else $error("converter gain 4x not decoded");

    a_cmp_gain: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i && cmp_dac_gain_select == VRTC_GAIN_OFF
        |=> !cmp_buf_on_o && cmp_gain_o == 3'h0)
        else $error("comparator gain off not decoded");

    a_range_sel: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i && temp_sense_enable && !temp_range_select
        |=> !temp_high_range_o)
        else $error("low range not selected");

endmodule // vrtc_top

// ===== tb/vrtc_top_tb_top.sv
`timescale 1ns/1ps
module vrtc_top_tb_top;
    import vrtc_pkg::*;

    // ************************************************************
    // Bench signals
    // ************************************************************
    localparam int SETTLE = 16;    // Shortened core settle count
    localparam int LIMIT  = 10000; // Cycle ceiling for the whole run
    localparam int TS_WAIT = 200 * VRTC_CLK_MHZ; // Sensor acquisition
    logic        clk = 1'b0;       // Bench clock
    logic        resetn = 1'b0;    // Reset, active low
    logic        cen;              // Clock enable to both designs
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rdata_f;   // Read data of both variants
    logic [31:0] dv, rdf;          // Captured read data
    logic [1:0]  rv;               // Captured response
    logic        ref_pwr, cbuf, mbuf, tpwr, trng;
    logic [2:0]  cgain, mgain;
    logic [4:0]  sel, och;         // Routing requests and results
    logic [7:0]  v;                // Control value under test
    int          bad_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    wire  [10:0] outs = {ref_pwr, cbuf, cgain, mbuf, mgain, tpwr, trng};

    // Clock at 20 MHz
    always #25 clk = ~clk;

    // ************************************************************
    // Designs: low-voltage variant and forced-ready variant
    // ************************************************************
    vrtc_top #(.LOW_VOLT_VARIANT(1'b1), .REF_SETTLE_CYC(SETTLE),
               .BUF_SETTLE_CYC(8)) i_dut (
        .ref_clk_i(clk), .resetn_i(resetn), .clk_en_i(cen),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .ref_power_o(ref_pwr),
        .conv_buf_on_o(cbuf), .conv_gain_o(cgain), .cmp_buf_on_o(mbuf),
        .cmp_gain_o(mgain), .temp_power_o(tpwr),
        .temp_high_range_o(trng), .conv_ch_ref_o(och[4]),
        .conv_pref_ref_o(och[3]), .cmp_pos_ref_o(och[2]),
        .dac_src_ref_o(och[1]), .conv_ch_temp_o(och[0]),
        .conv_sel_ref_i(sel[4]), .conv_sel_pref_i(sel[3]),
        .cmp_sel_ref_i(sel[2]), .dac_sel_ref_i(sel[1]),
        .conv_sel_temp_i(sel[0]));
    vrtc_top #(.LOW_VOLT_VARIANT(1'b0), .REF_SETTLE_CYC(SETTLE),
               .BUF_SETTLE_CYC(8)) i_dut_f (
        .ref_clk_i(clk), .resetn_i(resetn), .clk_en_i(cen),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(),
        .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_bvalid_o(), .s_axi_bready_i(bready), .s_axi_bresp_o(),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(),
        .s_axi_araddr_i(araddr), .s_axi_rvalid_o(),
        .s_axi_rready_i(rready), .s_axi_rdata_o(rdata_f),
        .s_axi_rresp_o(), .ref_power_o(), .conv_buf_on_o(),
        .conv_gain_o(), .cmp_buf_on_o(), .cmp_gain_o(), .temp_power_o(),
        .temp_high_range_o(), .conv_ch_ref_o(), .conv_pref_ref_o(),
        .cmp_pos_ref_o(), .dac_src_ref_o(), .conv_ch_temp_o(),
        .conv_sel_ref_i(sel[4]), .conv_sel_pref_i(sel[3]),
        .cmp_sel_ref_i(sel[2]), .dac_sel_ref_i(sel[1]),
        .conv_sel_temp_i(sel[0]));

    // ************************************************************
    // Expectations, bus tasks and comparisons
    // ************************************************************
    // One-hot amplifier select for a gain code
    function automatic logic [2:0] oh(input logic [1:0] c);
        return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
    endfunction
    // Analogue controls expected for a control value
    function automatic logic [10:0] expo(input logic [7:0] c);
        return {c[7], c[7] & (c[1:0] != 2'h0), oh(c[1:0]),
                c[7] & (c[3:2] != 2'h0), oh(c[3:2]), c[5], c[5] & c[4]};
    endfunction
    // Single comparison, counted
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", what, e, g);
            bad_count++;
        end
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wchk(input logic [3:0] a, input logic [7:0] d,
                        input logic [3:0] s, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask
    // Read and compare data and response
    task automatic rchk(input logic [3:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dv = rdata;
        rv = rresp;
        rdf = rdata_f;
        rready <= 1'b0;
        chk("rdata", e, dv);
        chk("rresp", {30'h0, er}, {30'h0, rv});
    endtask
    // Let control updates reach the outputs, then sample off the edge
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Final report and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            conclude();
        end
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        cen = 1'b1;
        {awaddr, araddr, wstrb, wdata, sel} = 49'h0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        // Reset state, both variants
        rchk(VRTC_OFS_CONTROL, 32'h0, VRTC_RESP_OKAY);
        chk("ready_f", 32'h40, rdf);
        chk("outs", 32'h0, {21'h0, outs});
        // Enable, then ready only after settling
        wchk(VRTC_OFS_CONTROL, 8'h80, 4'hf, VRTC_RESP_OKAY);
        settle();
        chk("outs", {21'h0, expo(8'h80)}, {21'h0, outs});
        rchk(VRTC_OFS_CONTROL, 32'h80, VRTC_RESP_OKAY);
        repeat (SETTLE + 4) @(posedge clk);
        rchk(VRTC_OFS_CONTROL, 32'hc0, VRTC_RESP_OKAY);
        chk("ready_f", 32'hc0, rdf);
        // Writing ready alone disables; re-enable restarts the count
        wchk(VRTC_OFS_CONTROL, 8'h40, 4'hf, VRTC_RESP_OKAY);
        rchk(VRTC_OFS_CONTROL, 32'h0, VRTC_RESP_OKAY);
        chk("ready_f", 32'h40, rdf);
        wchk(VRTC_OFS_CONTROL, 8'h80, 4'hf, VRTC_RESP_OKAY);
        rchk(VRTC_OFS_CONTROL, 32'h80, VRTC_RESP_OKAY);
        repeat (SETTLE + 4) @(posedge clk);
        // Every gain code on both paths, set to differing codes
        for (int c = 0; c < 4; c++) begin
            v = {4'h8, 2'(c), 2'(3 - c)};
            wchk(VRTC_OFS_CONTROL, v, 4'hf, VRTC_RESP_OKAY);
            settle();
            chk("outs", {21'h0, expo(v)}, {21'h0, outs});
            rchk(VRTC_OFS_CONTROL, {24'h0, v | 8'h40}, VRTC_RESP_OKAY);
        end
        // Low byte strobe off: nothing stored
        wchk(VRTC_OFS_CONTROL, 8'h00, 4'he, VRTC_RESP_OKAY);
        rchk(VRTC_OFS_CONTROL, 32'hcc, VRTC_RESP_OKAY);
        // Both buffers on, wait out their settle time
        wchk(VRTC_OFS_CONTROL, 8'h85, 4'hf, VRTC_RESP_OKAY);
        repeat (12) @(posedge clk);
        rchk(VRTC_OFS_STATUS, 32'h3, VRTC_RESP_OKAY);
        // Temperature sensor power and range
        for (int t = 1; t < 4; t++) begin
            v = {2'h0, 2'(t), 4'h0};
            wchk(VRTC_OFS_CONTROL, v, 4'hf, VRTC_RESP_OKAY);
            settle();
            chk("outs", {21'h0, expo(v)}, {21'h0, outs});
        end
        // Routing, one request at a time, sensor powered
        wchk(VRTC_OFS_CONTROL, 8'h20, 4'hf, VRTC_RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            sel <= 5'h1 << i;
            settle();
            chk("route", 32'h1 << i, {27'h0, och});
        end
        // Clock enable low freezes the routing outputs
        @(posedge clk);
        cen <= 1'b0;
        sel <= 5'h1;
        settle();
        chk("frozen", 32'h10, {27'h0, och});
        @(posedge clk);
        cen <= 1'b1;
        // Sensor channel held for the acquisition time before use
        repeat (TS_WAIT) @(posedge clk);
        #1;
        chk("route", 32'h1, {27'h0, och});
        // Sensor channel closed while sensor is off
        wchk(VRTC_OFS_CONTROL, 8'h00, 4'hf, VRTC_RESP_OKAY);
        settle();
        chk("route", 32'h0, {27'h0, och});
        // Unmapped address
        rchk(4'h8, 32'h0, VRTC_RESP_SLVERR);
        wchk(4'h8, 8'hbf, 4'hf, VRTC_RESP_SLVERR);
        rchk(VRTC_OFS_CONTROL, 32'h0, VRTC_RESP_OKAY);
        // Reset in mid-run clears every writable bit
        wchk(VRTC_OFS_CONTROL, 8'hbf, 4'hf, VRTC_RESP_OKAY);
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        chk("outs", 32'h0, {21'h0, outs});
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        rchk(VRTC_OFS_CONTROL, 32'h0, VRTC_RESP_OKAY);
        conclude();
    end

endmodule // vrtc_top_tb_top
